/* common/i2cme_params.svh */
// constants of the i2c master byte engine: widths, counts, reset values
// assumes inclusion by bare name from the package and the design modules
`ifndef I2CME_PARAMS_SVH
`define I2CME_PARAMS_SVH

// byte and counter widths
`define I2CME_BYTE_W    8
`define I2CME_BIT_W     4
`define I2CME_PH_W      2

// bit counter marks within one byte frame
`define I2CME_BIT_FIRST 4'h0
`define I2CME_BIT_LAST  4'h7
`define I2CME_BIT_ACK   4'h8
`define I2CME_BIT_STEP  4'h1

// phase codes inside a state
`define I2CME_PH_0      2'h0
`define I2CME_PH_1      2'h1
`define I2CME_PH_2      2'h2
`define I2CME_PH_STEP   2'h1

// reset and constant values
`define I2CME_BYTE_RST  8'h00
`define I2CME_CNT_ZERO  8'h00
`define I2CME_CNT_STEP  8'h01
`define I2CME_MSB       7

`endif

/* common/i2cme_pkg.sv */
// types shared by the i2c master byte engine
// assumes the constants header is on the include path
`include "i2cme_params.svh"

package i2cme_pkg;

  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_START  = 7'h02,
    ST_RSTART = 7'h04,
    ST_TX     = 7'h08,
    ST_RX     = 7'h10,
    ST_ACK    = 7'h20,
    ST_STOP   = 7'h40
  } i2cme_state_type;

  typedef logic [`I2CME_BYTE_W-1:0] i2cme_byte_type;

endpackage

/* common/i2cme_baud_if.sv */
// carrier between the byte engine and its baud timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "i2cme_params.svh"

interface i2cme_baud_if;
  logic                     load;    // reload count from reload value
  logic                     run;     // count while high
  logic [`I2CME_BYTE_W-1:0] reload;  // reload value
  logic                     tick;    // one-cycle rollover pulse

  modport timer (input load, input run, input reload, output tick);
  modport ctrl  (output load, output run, output reload, input tick);
endinterface

`default_nettype wire

/* core/i2cme_baud_timer.sv */
// baud timer: counts down from the reload value, pulses tick at zero
// assumes control from the byte engine on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "i2cme_params.svh"

module i2cme_baud_timer (
  // clock and reset
  input  wire logic    ref_clk_in,
  input  wire logic    rst_in,
  // control carrier
  i2cme_baud_if.timer  baud
);

  logic [`I2CME_BYTE_W-1:0] cnt_q;

  // =========================================================
  // down counter, reload on load or on rollover
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt_q <= `I2CME_CNT_ZERO;
    end else if (baud.load) begin
      cnt_q <= baud.reload;
    end else if (baud.run) begin
      if (cnt_q == `I2CME_CNT_ZERO) begin
        cnt_q <= baud.reload;
      end else begin
        cnt_q <= cnt_q - `I2CME_CNT_STEP;
      end
    end
  end

  // rollover marks the end of one baud period
  assign baud.tick = baud.run && !baud.load && (cnt_q == `I2CME_CNT_ZERO);

endmodule

`default_nettype wire

/* core/i2cme_engine.sv */
// i2c master byte engine: start, restart, transmit, receive, ack, stop
// assumes pulse commands from software logic on ref_clk_in and
// open-drain scl/sda pins resolved outside from the enables
`timescale 1ns/1ps
`default_nettype none
`include "i2cme_params.svh"

module i2cme_engine (
  // clock and reset
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_in,
  // software commands, one-cycle pulses
  input  wire logic                     buf_write_in,
  input  wire logic [`I2CME_BYTE_W-1:0] buf_wdata_in,
  input  wire logic                     buf_read_in,
  input  wire logic                     start_enable_set_in,
  input  wire logic                     restart_enable_set_in,
  input  wire logic                     stop_enable_set_in,
  input  wire logic                     receive_enable_set_in,
  input  wire logic                     ack_sequence_enable_set_in,
  // software configuration levels
  input  wire logic                     ack_data_bit_in,
  input  wire logic [`I2CME_BYTE_W-1:0] baud_reload_in,
  // software flag clears, one-cycle pulses
  input  wire logic                     write_collision_clear_in,
  input  wire logic                     receive_overflow_clear_in,
  input  wire logic                     serial_event_clear_in,
  // i2c pins, open drain
  input  wire logic                     scl_in,
  output var  logic                     scl_out,
  output var  logic                     scl_oe_n_out,
  input  wire logic                     sda_in,
  output var  logic                     sda_out,
  output var  logic                     sda_oe_n_out,
  // status
  output var  logic [`I2CME_BYTE_W-1:0] data_buffer_out,
  output var  logic                     byte_full_flag_out,
  output var  logic                     write_collision_flag_out,
  output var  logic                     receive_overflow_flag_out,
  output var  logic                     ack_status_bit_out,
  output var  logic                     serial_event_flag_out,
  output var  logic                     stop_seen_bit_out,
  // enable bits as seen by software
  output var  logic                     start_enable_out,
  output var  logic                     restart_enable_out,
  output var  logic                     stop_enable_out,
  output var  logic                     receive_enable_out,
  output var  logic                     ack_sequence_enable_out
);

  // ==========================================================
  // declarations
  i2cme_pkg::i2cme_state_type state_q;
  logic [`I2CME_PH_W-1:0]     ph_q;
  logic [`I2CME_BIT_W-1:0]    bit_q;
  logic                       ld_q;
  i2cme_pkg::i2cme_byte_type  shift_register_q;
  logic                       scl_m_q;
  logic                       scl_s_q;
  logic                       sda_m_q;
  logic                       sda_s_q;
  logic                       idle;
  logic                       go_tx;
  logic                       go_start;
  logic                       go_rstart;
  logic                       go_stop;
  logic                       go_rx;
  logic                       go_ack;
  logic                       hi_end;
  logic                       tx_last_shift;
  logic                       tx_ack_end;
  logic                       rx_done;
  logic                       start_done;
  logic                       rstart_done;
  logic                       ack_done;
  logic                       stop_done;
  logic                       wait_c;

  i2cme_baud_if baud ();

  // shift one sampled bit into the low end of a byte
  function automatic i2cme_pkg::i2cme_byte_type shift_in(
    input i2cme_pkg::i2cme_byte_type cur,
    input logic                      b
  );
    shift_in = {cur[`I2CME_MSB-1:0], b};
  endfunction

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      scl_m_q <= 1'h1;
      scl_s_q <= 1'h1;
      sda_m_q <= 1'h1;
      sda_s_q <= 1'h1;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
    end
  end

  // ==========================================================
  // command acceptance, only from idle, data write first
  assign idle = (state_q == i2cme_pkg::ST_IDLE);

  always_comb begin
    go_tx     = 1'b0;
    go_start  = 1'b0;
    go_rstart = 1'b0;
    go_stop   = 1'b0;
    go_rx     = 1'b0;
    go_ack    = 1'b0;
    if (idle) begin
      if (buf_write_in) begin
        go_tx = 1'b1;
      end else if (start_enable_set_in) begin
        go_start = 1'b1;
      end else if (restart_enable_set_in) begin
        go_rstart = 1'b1;
      end else if (stop_enable_set_in) begin
        go_stop = 1'b1;
      end else if (receive_enable_set_in) begin
        go_rx = 1'b1;
      end else if (ack_sequence_enable_set_in) begin
        go_ack = 1'b1;
      end
    end
  end

  // completion decodes
  assign hi_end        = baud.tick && (ph_q == `I2CME_PH_1);
  assign tx_last_shift = (state_q == i2cme_pkg::ST_TX) && hi_end
                         && (bit_q == `I2CME_BIT_LAST);
  assign tx_ack_end    = (state_q == i2cme_pkg::ST_TX) && hi_end
                         && (bit_q == `I2CME_BIT_ACK);
  assign rx_done       = (state_q == i2cme_pkg::ST_RX) && hi_end
                         && (bit_q == `I2CME_BIT_LAST);
  assign start_done    = (state_q == i2cme_pkg::ST_START) && hi_end;
  assign rstart_done   = (state_q == i2cme_pkg::ST_RSTART) && baud.tick
                         && (ph_q == `I2CME_PH_2);
  assign ack_done      = (state_q == i2cme_pkg::ST_ACK) && hi_end;
  assign stop_done     = (state_q == i2cme_pkg::ST_STOP) && baud.tick
                         && (ph_q == `I2CME_PH_2);

  // ==========================================================
  // baud timer control: hold in reload while a level is awaited
  always_comb begin
    wait_c = !idle && scl_oe_n_out && !scl_s_q;
    if ((state_q == i2cme_pkg::ST_STOP) && (ph_q == `I2CME_PH_0) && sda_s_q) begin
      wait_c = 1'b1;
    end
    if ((state_q == i2cme_pkg::ST_STOP) && (ph_q == `I2CME_PH_2) && !sda_s_q) begin
      wait_c = 1'b1;
    end
    if ((state_q == i2cme_pkg::ST_START) && (ph_q == `I2CME_PH_0)
        && !(sda_s_q && scl_s_q)) begin
      wait_c = 1'b1;
    end
  end

  assign baud.run    = !idle;
  assign baud.load   = ld_q || wait_c || idle;
  assign baud.reload = baud_reload_in;

  i2cme_baud_timer u_baud (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .baud       (baud)
  );

  // ==========================================================
  // sequencer: state, phase and bit counter
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= i2cme_pkg::ST_IDLE;
      ph_q    <= `I2CME_PH_0;
      bit_q   <= `I2CME_BIT_FIRST;
      ld_q    <= 1'b0;
    end else begin
      ld_q <= 1'b0;
      case (state_q)
        i2cme_pkg::ST_IDLE: begin
          ph_q  <= `I2CME_PH_0;
          bit_q <= `I2CME_BIT_FIRST;
          ld_q  <= 1'b1;
          if (go_tx) begin
            state_q <= i2cme_pkg::ST_TX;
          end else if (go_start) begin
            state_q <= i2cme_pkg::ST_START;
          end else if (go_rstart) begin
            state_q <= i2cme_pkg::ST_RSTART;
          end else if (go_stop) begin
            state_q <= i2cme_pkg::ST_STOP;
          end else if (go_rx) begin
            state_q <= i2cme_pkg::ST_RX;
          end else if (go_ack) begin
            state_q <= i2cme_pkg::ST_ACK;
          end
        end
        i2cme_pkg::ST_TX, i2cme_pkg::ST_RX: begin
          if (baud.tick) begin
            ld_q <= 1'b1;
            if (ph_q == `I2CME_PH_0) begin
              ph_q <= `I2CME_PH_1;
            end else begin
              ph_q <= `I2CME_PH_0;
              if (tx_ack_end || rx_done) begin
                state_q <= i2cme_pkg::ST_IDLE;
              end else begin
                bit_q <= bit_q + `I2CME_BIT_STEP;
              end
            end
          end
        end
        i2cme_pkg::ST_START, i2cme_pkg::ST_ACK: begin
          if (baud.tick) begin
            ld_q <= 1'b1;
            if (ph_q == `I2CME_PH_0) begin
              ph_q <= `I2CME_PH_1;
            end else begin
              state_q <= i2cme_pkg::ST_IDLE;
            end
          end
        end
        i2cme_pkg::ST_RSTART, i2cme_pkg::ST_STOP: begin
          if (baud.tick) begin
            ld_q <= 1'b1;
            if (ph_q == `I2CME_PH_2) begin
              state_q <= i2cme_pkg::ST_IDLE;
            end else begin
              ph_q <= ph_q + `I2CME_PH_STEP;
            end
          end
        end
        default: begin
          state_q <= i2cme_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // pin drivers: enable low pulls the line low
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      scl_oe_n_out <= 1'b1;
      sda_oe_n_out <= 1'b1;
    end else begin
      case (state_q)
        i2cme_pkg::ST_IDLE: begin
          if (go_tx) begin
            scl_oe_n_out <= 1'b0;
            sda_oe_n_out <= buf_wdata_in[`I2CME_MSB];
          end else if (go_start) begin
            scl_oe_n_out <= 1'b1;
            sda_oe_n_out <= 1'b1;
          end else if (go_rstart) begin
            scl_oe_n_out <= 1'b0;
            sda_oe_n_out <= 1'b1;
          end else if (go_stop) begin
            scl_oe_n_out <= 1'b0;
            sda_oe_n_out <= 1'b0;
          end else if (go_rx) begin
            scl_oe_n_out <= 1'b0;
            sda_oe_n_out <= 1'b1;
          end else if (go_ack) begin
            scl_oe_n_out <= 1'b0;
            sda_oe_n_out <= ack_data_bit_in;
          end
        end
        i2cme_pkg::ST_TX: begin
          if (baud.tick) begin
            if (ph_q == `I2CME_PH_0) begin
              scl_oe_n_out <= 1'b1;
            end else begin
              scl_oe_n_out <= 1'b0;
              if (bit_q < `I2CME_BIT_LAST) begin
                sda_oe_n_out <= shift_register_q[`I2CME_MSB-1];
              end else begin
                sda_oe_n_out <= 1'b1; // free sda for the slave ack
              end
            end
          end
        end
        i2cme_pkg::ST_RX: begin
          if (baud.tick) begin
            scl_oe_n_out <= (ph_q == `I2CME_PH_0);
          end
        end
        i2cme_pkg::ST_START: begin
          if (baud.tick && (ph_q == `I2CME_PH_0)) begin
            sda_oe_n_out <= 1'b0;
          end
        end
        i2cme_pkg::ST_RSTART: begin
          if (baud.tick) begin
            if (ph_q == `I2CME_PH_0) begin
              scl_oe_n_out <= 1'b1;
            end else if (ph_q == `I2CME_PH_1) begin
              sda_oe_n_out <= 1'b0;
            end else begin
              scl_oe_n_out <= 1'b0;
            end
          end
        end
        i2cme_pkg::ST_ACK: begin
          if (baud.tick) begin
            if (ph_q == `I2CME_PH_0) begin
              scl_oe_n_out <= 1'b1;
            end else begin
              scl_oe_n_out <= 1'b0;
              sda_oe_n_out <= 1'b1;
            end
          end
        end
        i2cme_pkg::ST_STOP: begin
          if (baud.tick) begin
            if (ph_q == `I2CME_PH_0) begin
              scl_oe_n_out <= 1'b1;
            end else if (ph_q == `I2CME_PH_1) begin
              sda_oe_n_out <= 1'b1;
            end
          end
        end
        default: begin
          scl_oe_n_out <= 1'b1;
          sda_oe_n_out <= 1'b1;
        end
      endcase
    end
  end

  // driven level of both open-drain pins is always low
  always_ff @(posedge ref_clk_in) begin
    scl_out <= 1'b0;
    sda_out <= 1'b0;
  end

  // ==========================================================
  // shift register and data buffer
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      shift_register_q <= `I2CME_BYTE_RST;
      data_buffer_out  <= `I2CME_BYTE_RST;
    end else begin
      if (go_tx) begin
        shift_register_q <= buf_wdata_in;
        data_buffer_out  <= buf_wdata_in;
      end else if (go_rx) begin
        shift_register_q <= `I2CME_BYTE_RST;
      end else if ((state_q == i2cme_pkg::ST_TX) && hi_end) begin
        shift_register_q <= shift_in(shift_register_q, 1'b0);
      end else if ((state_q == i2cme_pkg::ST_RX) && hi_end) begin
        shift_register_q <= shift_in(shift_register_q, sda_s_q);
        if (rx_done) begin
          data_buffer_out <= shift_in(shift_register_q, sda_s_q);
        end
      end
    end
  end

  // ==========================================================
  // acknowledge status and stop seen
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ack_status_bit_out <= 1'b0;
      stop_seen_bit_out  <= 1'b0;
    end else begin
      if (tx_ack_end) begin
        ack_status_bit_out <= sda_s_q;
      end
      if ((state_q == i2cme_pkg::ST_STOP) && (ph_q == `I2CME_PH_2)
          && sda_s_q && scl_s_q) begin
        stop_seen_bit_out <= 1'b1;
      end else if (go_start || go_rstart) begin
        stop_seen_bit_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // buffer full: set wins over clear
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      byte_full_flag_out <= 1'b0;
    end else if (go_tx || rx_done) begin
      byte_full_flag_out <= 1'b1;
    end else if (tx_last_shift || buf_read_in) begin
      byte_full_flag_out <= 1'b0;
    end
  end

  // ==========================================================
  // sticky error flags, software cleared, set wins
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      write_collision_flag_out  <= 1'b0;
      receive_overflow_flag_out <= 1'b0;
    end else begin
      if (buf_write_in && !idle) begin
        write_collision_flag_out <= 1'b1;
      end else if (write_collision_clear_in) begin
        write_collision_flag_out <= 1'b0;
      end
      if (rx_done && byte_full_flag_out) begin
        receive_overflow_flag_out <= 1'b1;
      end else if (receive_overflow_clear_in) begin
        receive_overflow_flag_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // serial event flag, cleared only by software
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      serial_event_flag_out <= 1'b0;
    end else if (start_done || rstart_done || stop_done) begin
      serial_event_flag_out <= 1'b1;
    end else if (tx_ack_end || rx_done || ack_done) begin
      serial_event_flag_out <= 1'b1;
    end else if (serial_event_clear_in) begin
      serial_event_flag_out <= 1'b0;
    end
  end

  // ==========================================================
  // enable bits: set on acceptance, cleared by hardware at the end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      start_enable_out        <= 1'b0;
      restart_enable_out      <= 1'b0;
      stop_enable_out         <= 1'b0;
      receive_enable_out      <= 1'b0;
      ack_sequence_enable_out <= 1'b0;
    end else begin
      if (go_start) begin
        start_enable_out <= 1'b1;
      end else if (start_done) begin
        start_enable_out <= 1'b0;
      end
      if (go_rstart) begin
        restart_enable_out <= 1'b1;
      end else if (rstart_done) begin
        restart_enable_out <= 1'b0;
      end
      if (go_stop) begin
        stop_enable_out <= 1'b1;
      end else if (stop_done) begin
        stop_enable_out <= 1'b0;
      end
      if (go_rx) begin
        receive_enable_out <= 1'b1;
      end else if (rx_done) begin
        receive_enable_out <= 1'b0;
      end
      if (go_ack) begin
        ack_sequence_enable_out <= 1'b1;
      end else if (ack_done) begin
        ack_sequence_enable_out <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* sim/i2cme_slave_model.sv */
// slave model on scl and sda: acks written bytes, sends bytes on reads
// assumes a pulled-up bus resolved by the bench
`timescale 1ns/1ps
`default_nettype none

module i2cme_slave_model (
  // reset and bus clock
  input  wire logic       rst_in,
  input  wire logic       scl_in,
  // read mode, refuse ack, byte to send
  input  wire logic       rd_in,
  input  wire logic       nack_in,
  input  wire logic [7:0] rxb_in,
  // open-drain data, low pulls the line
  output var  logic       sda_oe_n_out
);
  // ==================================================
  // frame of eight data bits and one ack bit
  logic [3:0] cnt_q;

  // count clock rises within a frame
  always @(posedge scl_in or posedge rst_in) begin
    if (rst_in) cnt_q <= 4'h0;
    else cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
  end

  // data changes only while the clock is low
  always @(negedge scl_in or posedge rd_in or posedge rst_in) begin
    if (rst_in) sda_oe_n_out <= 1'b1;
    else if (rd_in) sda_oe_n_out <= (cnt_q < 4'h8) ? rxb_in[3'h7 - cnt_q[2:0]] : 1'b1;
    else sda_oe_n_out <= (cnt_q == 4'h8) ? nack_in : 1'b1;
  end
endmodule

`default_nettype wire

/* sim/i2cme_engine_chk.sv */
// port checks of the byte engine
// assumes a bind onto i2cme_engine, one clock domain
`timescale 1ns/1ps
`default_nettype none

module i2cme_engine_chk (
  // clock, reset, strobes
  input wire logic       ref_clk_in, rst_in, buf_write_in, buf_read_in,
  input wire logic       ack_data_bit_in, write_collision_clear_in,
  // pins and status
  input wire logic       scl_oe_n_out, sda_oe_n_out, byte_full_flag_out,
  input wire logic       write_collision_flag_out, receive_overflow_flag_out,
  input wire logic       ack_status_bit_out, serial_event_flag_out, stop_seen_bit_out,
  input wire logic       stop_enable_out, receive_enable_out, ack_sequence_enable_out,
  input wire logic [7:0] data_buffer_out,
  input wire logic [7:0] baud_reload_in
);
  // ==================================================
  // relations between commands, flags and pins
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  coll_busy_a: assert property (
    buf_write_in && (receive_enable_out || ack_sequence_enable_out || stop_enable_out)
    |=> write_collision_flag_out && $stable(data_buffer_out)) else $error("write taken");
  coll_hold_a: assert property (
    write_collision_flag_out && !write_collision_clear_in |=> write_collision_flag_out)
    else $error("collision lost");
  ack_cap_a: assert property (
    $changed(ack_status_bit_out) |-> serial_event_flag_out) else $error("ack status early");
  rx_done_a: assert property (
    $fell(receive_enable_out) |-> byte_full_flag_out && serial_event_flag_out && !scl_oe_n_out)
    else $error("receive end wrong");
  rx_ovf_a: assert property (
    $fell(receive_enable_out) && $past(byte_full_flag_out) && !$past(buf_read_in)
    |-> receive_overflow_flag_out) else $error("no overflow");
  ack_drv_a: assert property (
    $rose(ack_sequence_enable_out) |-> !scl_oe_n_out && sda_oe_n_out == $past(ack_data_bit_in))
    else $error("ack drive wrong");
  ack_end_a: assert property (
    $fell(ack_sequence_enable_out) |-> !scl_oe_n_out && serial_event_flag_out)
    else $error("ack end wrong");
  stop_end_a: assert property (
    $fell(stop_enable_out) |-> stop_seen_bit_out && serial_event_flag_out && scl_oe_n_out
    && sda_oe_n_out) else $error("stop end wrong");
  ack_period_a: assert property (
    $rose(ack_sequence_enable_out) && baud_reload_in == 8'h03
    |-> ##4 !scl_oe_n_out ##1 scl_oe_n_out) else $error("ack low time wrong");
endmodule

bind i2cme_engine i2cme_engine_chk u_chk (.*);

`default_nettype wire

/* sim/i2c_master_byte_engine_tb.sv */
// bench of the byte engine against the slave model
// assumes design, package, checker and model compiled first
`timescale 1ns/1ps
`default_nettype none

module i2c_master_byte_engine_tb;
  logic        clk, ev_q = 1'b0, rst, rd = 1'b0, nack = 1'b1, ackbit = 1'b0;
  logic [9:0]  cmd = 10'h000;
  logic [7:0]  wd = 8'h00, rxb = 8'h00, r1, r2, dbuf;
  logic [31:0] s = 32'h00004946;
  logic [12:0] note_q[$];
  logic        scl_oe_n, sda_oe_n, slv_oe_n, bf, wc, ov, ack_st, ev, ss;
  int          mismatches = 0, check_count = 0, cyc = 0;
  wire logic   sda_w = sda_oe_n & slv_oe_n;

  // ==================================================
  // design, slave and clock
  i2cme_engine dut (.ref_clk_in(clk), .rst_in(rst), .buf_write_in(cmd[5]),
    .buf_wdata_in(wd), .buf_read_in(cmd[6]), .start_enable_set_in(cmd[0]),
    .restart_enable_set_in(cmd[1]), .stop_enable_set_in(cmd[2]),
    .receive_enable_set_in(cmd[3]), .ack_sequence_enable_set_in(cmd[4]),
    .ack_data_bit_in(ackbit), .baud_reload_in(8'h03), .write_collision_clear_in(cmd[7]),
    .receive_overflow_clear_in(cmd[8]), .serial_event_clear_in(cmd[9]),
    .scl_in(scl_oe_n), .scl_out(), .scl_oe_n_out(scl_oe_n), .sda_in(sda_w), .sda_out(),
    .sda_oe_n_out(sda_oe_n), .data_buffer_out(dbuf), .byte_full_flag_out(bf),
    .write_collision_flag_out(wc), .receive_overflow_flag_out(ov),
    .ack_status_bit_out(ack_st), .serial_event_flag_out(ev), .stop_seen_bit_out(ss),
    .start_enable_out(), .restart_enable_out(), .stop_enable_out(),
    .receive_enable_out(), .ack_sequence_enable_out());
  i2cme_slave_model slave (.rst_in(rst), .scl_in(scl_oe_n), .rd_in(rd), .nack_in(nack),
    .rxb_in(rxb), .sda_oe_n_out(slv_oe_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string n, input logic [12:0] seen, input logic [12:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // one-cycle command pulse, then a quiet edge
  task automatic go(input int k);
    cmd <= 10'h001 << k;
    @(posedge clk);
    cmd <= 10'h000;
    @(posedge clk);
  endtask

  // bounded wait for the event flag, then clear it
  task automatic wt();
    repeat (2000) if (ev !== 1'b1) @(posedge clk);
    go(9);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // status vector {buffer, ack, full, overflow, collision, stop} at each event
  always @(posedge clk) begin
    ev_q <= ev;
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      give_verdict();
    end
    if (ev === 1'b1 && ev_q === 1'b0) begin
      if (note_q.size() == 0) chk("extra event", 13'h0000, 13'h1FFF);
      else chk("status", {dbuf, ack_st, bf, ov, wc, ss}, note_q.pop_front());
    end
  end

  // start, nack byte, address with collision, two receives, acks, stop, restart
  initial begin
    rst <= 1'b1; // edge at time zero also resets the slave model
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    note_q.push_back(13'h0000);
    go(0);
    wt();
    s = xs(s);
    wd <= s[7:0];
    note_q.push_back({s[7:0], 5'h10});
    go(5);
    wt();
    s = xs(s);
    nack <= 1'b0;
    wd <= s[7:0] | 8'h01;
    note_q.push_back({s[7:0] | 8'h01, 5'h02});
    go(5);
    wd <= ~s[7:0];
    go(5);
    go(3);
    wt();
    go(7);
    s = xs(s);
    r1 = s[7:0];
    r2 = s[15:8];
    rxb <= r1;
    rd <= 1'b1;
    note_q.push_back({r1, 5'h0A});
    go(3);
    wd <= r2;
    go(5);
    wt();
    go(7);
    rxb <= r2;
    note_q.push_back({r1, 5'h0A});
    go(4);
    go(5);
    wt();
    go(7);
    note_q.push_back({r2, 5'h0C});
    go(3);
    wt();
    go(6);
    chk("full after read", {12'h000, bf}, 13'h0000);
    go(8);
    rd <= 1'b0;
    ackbit <= 1'b1;
    note_q.push_back({r2, 5'h00});
    go(4);
    wt();
    note_q.push_back({r2, 5'h01});
    go(2);
    wt();
    chk("bus idle", {11'h000, scl_oe_n, sda_w}, 13'h0003);
    note_q.push_back({r2, 5'h00});
    go(1);
    wt();
    chk("notes left", 13'(note_q.size()), 13'h0000);
    give_verdict();
  end
endmodule

`default_nettype wire
